// ### src/lbcs_top.sv
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "lbcs_params.svh"

// Summary of operation
// - Send-first flag sets when a marked transmit count hits zero with the send request set.
// - Send-first flag also sets on fetching a transmit control byte with bit 3 set.
// - Send-first flag clears once the first check byte is loaded for transmit.
// - Loading the first check byte sets send-second, cleared at once for single byte check.
// - Send-second flag clears when the second check byte is loaded.
// - Escape flag sets on loading an escape byte for control bit 1 and clears when sent.
// - Expect-first sets on receive count zero with expect request, or control byte bit 3.
// - While expect-first is set the next received byte enters the check calculation.
// - Completion posts high OR low accumulator bytes, line and code 0101 to the result reg.
// - Completion writes a discard control byte with bit 4 set.
// - Completion sets system control bit 7 to interrupt the host.
// - Two byte checks set expect-second and defer posting until the second byte.
// - Expect-second sets as expect-first falls during reception under a two byte check.
// - While expect-second is set the next byte is taken, then the result is posted.
module lbcs_top
    import lbcs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // per line events
    input wire lbcs_tx_ev_t [`LBCS_LINES-1:0] tx_ev,
    input wire lbcs_rx_ev_t [`LBCS_LINES-1:0] rx_ev,
    // outputs
    output logic [7:0] discard_ctrl,
    output logic discard_valid,
    output logic irq
);
    typedef struct packed {
        logic [`LBCS_LINE_W-1:0] line_sel;
        logic [`LBCS_LINES*2-1:0] check_type;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [15:0] receiver_interrupt_char_reg;
        logic [7:0] ctrl_byte;
        logic [7:0] sys_ctrl;
        logic [15:0] rdata;
        logic discard_valid;
        logic irq;
        logic post_pend;
        logic [`LBCS_LINE_W-1:0] post_line;
    } lbcs_top_state_t;

    lbcs_top_state_t s_q, s_d;
    lbcs_line_t [`LBCS_LINES-1:0] line_q;
    logic [`LBCS_LINES-1:0] rx_done, tx_done;
    logic [`LBCS_LINES-1:0] line_wr;
    logic any_rx, any_tx;
    logic [`LBCS_LINE_W-1:0] rx_line;
    logic [15:0] progress_rd;

    // -------------------------------------------------------------------
    // per line state
    // -------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `LBCS_LINES; g++) begin : g_line
            assign line_wr[g] = reg_wr && (reg_addr == `LBCS_ADDR_PROGRESS)
                && (s_q.line_sel == `LBCS_LINE_W'(g));
            lbcs_line u_line (
                .clk(clk),
                .rst(rst),
                .check_type(s_q.check_type[g*2 +: 2]),
                .wr_req(line_wr[g]),
                .send_req_wr(reg_wdata[`LBCS_BIT_SEND_REQ]),
                .expect_req_wr(reg_wdata[`LBCS_BIT_EXPECT_REQ]),
                .tx_ev(tx_ev[g]),
                .rx_ev(rx_ev[g]),
                .line_q_o(line_q[g]),
                .rx_done(rx_done[g]),
                .tx_done(tx_done[g])
            );

            logic pair_check;
            assign pair_check = (s_q.check_type[g*2 +: 2] == `LBCS_CT_CRC16)
                || (s_q.check_type[g*2 +: 2] == `LBCS_CT_CCITT);

            chk_ctrl_send_first: assert property (@(posedge clk) disable iff (rst)
                (tx_ev[g].ctrl_fetch && tx_ev[g].ctrl_byte[`LBCS_CB_CHECK])
                    |=> line_q[g].send_first)
                else $error("send first flag not set by control byte");

            chk_first_clear: assert property (@(posedge clk) disable iff (rst)
                (tx_ev[g].load_first && !tx_ev[g].count_zero && !tx_ev[g].ctrl_fetch)
                    |=> !line_q[g].send_first)
                else $error("send first flag not cleared on load");

            chk_second_set: assert property (@(posedge clk) disable iff (rst)
                (tx_ev[g].load_first && pair_check && !tx_ev[g].load_second)
                    |=> line_q[g].send_second)
                else $error("send second flag not set under two byte check");

            chk_esc_set: assert property (@(posedge clk) disable iff (rst)
                (tx_ev[g].esc_load && tx_ev[g].ctrl_byte[`LBCS_CB_ESCAPE])
                    |=> line_q[g].esc_sending)
                else $error("escape flag not set on escape load");

            chk_esc_clear: assert property (@(posedge clk) disable iff (rst)
                (tx_ev[g].esc_sent && !tx_ev[g].esc_load) |=> !line_q[g].esc_sending)
                else $error("escape flag not cleared once sent");

            chk_expect_count: assert property (@(posedge clk) disable iff (rst)
                (rx_ev[g].count_zero && line_q[g].expect_req) |=> line_q[g].expect_first)
                else $error("expect first flag not set at count zero");

            chk_expect_ctrl: assert property (@(posedge clk) disable iff (rst)
                (rx_ev[g].ctrl_fetch && rx_ev[g].ctrl_byte[`LBCS_CB_CHECK])
                    |=> line_q[g].expect_first)
                else $error("expect first flag not set by control byte");

            chk_first_taken: assert property (@(posedge clk) disable iff (rst)
                (rx_ev[g].char_valid && line_q[g].expect_first
                    && !rx_ev[g].count_zero && !rx_ev[g].ctrl_fetch)
                    |=> !line_q[g].expect_first)
                else $error("first check char not consumed");

            chk_single_done: assert property (@(posedge clk) disable iff (rst)
                (rx_ev[g].char_valid && line_q[g].expect_first && !pair_check)
                    |=> !line_q[g].expect_second)
                else $error("second check char expected under single byte check");

            chk_second_taken: assert property (@(posedge clk) disable iff (rst)
                (rx_ev[g].char_valid && line_q[g].expect_second && !line_q[g].expect_first)
                    |=> !line_q[g].expect_second)
                else $error("second check char not consumed");
        end
    endgenerate

    always_comb begin
        any_rx = 1'b0;
        any_tx = 1'b0;
        rx_line = '0;
        for (int i = 0; i < `LBCS_LINES; i++) begin
            if (tx_done[i]) begin
                any_tx = 1'b1;
            end
            if (rx_done[i] && !any_rx) begin
                any_rx = 1'b1;
                rx_line = i[`LBCS_LINE_W-1:0];
            end
        end
    end

    // progress view of selected line; flags read only
    always_comb begin
        progress_rd = 16'h0000;
        progress_rd[`LBCS_BIT_SEND_FIRST] = line_q[s_q.line_sel].send_first;
        progress_rd[`LBCS_BIT_SEND_SECOND] = line_q[s_q.line_sel].send_second;
        progress_rd[`LBCS_BIT_ESC_SENDING] = line_q[s_q.line_sel].esc_sending;
        progress_rd[`LBCS_BIT_EXPECT_FIRST] = line_q[s_q.line_sel].expect_first;
        progress_rd[`LBCS_BIT_EXPECT_SECOND] = line_q[s_q.line_sel].expect_second;
        progress_rd[`LBCS_BIT_SEND_REQ] = line_q[s_q.line_sel].send_req;
        progress_rd[`LBCS_BIT_EXPECT_REQ] = line_q[s_q.line_sel].expect_req;
    end

    // -------------------------------------------------------------------
    // registers and completion posting
    // -------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.discard_valid = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                `LBCS_ADDR_LINE_SEL: s_d.line_sel = reg_wdata[`LBCS_LINE_W-1:0];
                `LBCS_ADDR_CHECK_TYPE: s_d.check_type = reg_wdata[`LBCS_LINES*2-1:0];
                `LBCS_ADDR_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~reg_wdata[1:0];
                `LBCS_ADDR_IRQ_MASK: s_d.irq_mask = reg_wdata[1:0];
                `LBCS_ADDR_SYS_CTRL: s_d.sys_ctrl = reg_wdata[7:0];
                default: s_d.line_sel = s_q.line_sel;
            endcase
        end
        // posted a cycle after the last check char, once its line has folded it in
        s_d.post_pend = any_rx;
        s_d.post_line = rx_line;
        if (s_q.post_pend) begin
            s_d.receiver_interrupt_char_reg = {2'h0, s_q.post_line, `LBCS_RIC_CODE,
                line_q[s_q.post_line].accum[15:8] | line_q[s_q.post_line].accum[7:0]};
            s_d.ctrl_byte = 8'h00;
            s_d.ctrl_byte[`LBCS_CB_DISCARD] = 1'b1;
            s_d.discard_valid = 1'b1;
            s_d.sys_ctrl[`LBCS_SCR_IRQ_BIT] = 1'b1;
            s_d.irq_stat[`LBCS_IRQ_RX_DONE] = 1'b1;
        end
        if (any_tx) begin
            s_d.irq_stat[`LBCS_IRQ_TX_DONE] = 1'b1;
        end
        s_d.rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                `LBCS_ADDR_PROGRESS: s_d.rdata = progress_rd;
                `LBCS_ADDR_LINE_SEL: s_d.rdata = {14'h0000, s_q.line_sel};
                `LBCS_ADDR_CHECK_TYPE: s_d.rdata = {8'h00, s_q.check_type};
                `LBCS_ADDR_IRQ_STAT: s_d.rdata = {14'h0000, s_q.irq_stat};
                `LBCS_ADDR_IRQ_MASK: s_d.rdata = {14'h0000, s_q.irq_mask};
                `LBCS_ADDR_RIC: s_d.rdata = s_q.receiver_interrupt_char_reg;
                `LBCS_ADDR_CTRL_BYTE: s_d.rdata = {8'h00, s_q.ctrl_byte};
                `LBCS_ADDR_SYS_CTRL: s_d.rdata = {8'h00, s_q.sys_ctrl};
                default: s_d.rdata = 16'h0000;
            endcase
        end
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign discard_ctrl = s_q.ctrl_byte;
    assign discard_valid = s_q.discard_valid;
    assign irq = s_q.irq;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    sequence s_done;
        any_rx;
    endsequence
    sequence s_posted;
        discard_valid && discard_ctrl[`LBCS_CB_DISCARD] && s_q.receiver_interrupt_char_reg[11:8] == `LBCS_RIC_CODE;
    endsequence

    chk_post_result: assert property (@(posedge clk) disable iff (rst)
        s_done |-> ##2 s_posted)
        else $error("check result not posted");

    chk_discard_byte: assert property (@(posedge clk) disable iff (rst)
        discard_valid |-> discard_ctrl == 8'h10)
        else $error("discard control byte wrong");

    chk_sys_irq: assert property (@(posedge clk) disable iff (rst)
        s_done |-> ##2 s_q.sys_ctrl[`LBCS_SCR_IRQ_BIT])
        else $error("system control interrupt bit not set");

    chk_rx_stat_set: assert property (@(posedge clk) disable iff (rst)
        s_done |-> ##2 s_q.irq_stat[`LBCS_IRQ_RX_DONE])
        else $error("receive status not set on completion");

    chk_irq_level: assert property (@(posedge clk) disable iff (rst)
        irq == |(s_q.irq_stat & s_q.irq_mask))
        else $error("interrupt level mismatch");

    chk_stat_clear: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && reg_addr == `LBCS_ADDR_IRQ_STAT && reg_wdata[`LBCS_IRQ_RX_DONE]
            && !s_q.post_pend) |=> !s_q.irq_stat[`LBCS_IRQ_RX_DONE])
        else $error("receive status not cleared by writing one");

    chk_tx_stat_set: assert property (@(posedge clk) disable iff (rst)
        (|tx_done) |=> s_q.irq_stat[`LBCS_IRQ_TX_DONE])
        else $error("transmit status not set");

    chk_rdata_idle: assert property (@(posedge clk) disable iff (rst)
        !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");

    chk_result_kept: assert property (@(posedge clk) disable iff (rst)
        !s_q.post_pend |=> $stable(s_q.receiver_interrupt_char_reg))
        else $error("result register changed without a completion");

    chk_ctrl_kept: assert property (@(posedge clk) disable iff (rst)
        !s_q.post_pend |=> $stable(s_q.ctrl_byte))
        else $error("control byte changed without a completion");

    chk_type_write: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && reg_addr == `LBCS_ADDR_CHECK_TYPE)
            |=> s_q.check_type == $past(reg_wdata[`LBCS_LINES*2-1:0]))
        else $error("check type write lost");

    chk_sys_write: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && reg_addr == `LBCS_ADDR_SYS_CTRL && !s_q.post_pend)
            |=> s_q.sys_ctrl == $past(reg_wdata[7:0]))
        else $error("system control write lost");
endmodule

// ### inc/lbcs_params.svh
`ifndef LBCS_PARAMS_SVH
`define LBCS_PARAMS_SVH

// register offsets, byte addresses
`define LBCS_ADDR_PROGRESS 8'h00
`define LBCS_ADDR_LINE_SEL 8'h04
`define LBCS_ADDR_CHECK_TYPE 8'h08
`define LBCS_ADDR_IRQ_STAT 8'h0C
`define LBCS_ADDR_IRQ_MASK 8'h10
`define LBCS_ADDR_RIC 8'h14
`define LBCS_ADDR_CTRL_BYTE 8'h18
`define LBCS_ADDR_SYS_CTRL 8'h1C

// progress register bit positions
`define LBCS_BIT_SEND_FIRST 0
`define LBCS_BIT_SEND_SECOND 1
`define LBCS_BIT_ESC_SENDING 2
`define LBCS_BIT_EXPECT_FIRST 5
`define LBCS_BIT_EXPECT_SECOND 6
`define LBCS_BIT_SEND_REQ 10
`define LBCS_BIT_EXPECT_REQ 11

// control byte bit positions
`define LBCS_CB_ESCAPE 1
`define LBCS_CB_CHECK 3
`define LBCS_CB_DISCARD 4

// system control bit, interrupt code
`define LBCS_SCR_IRQ_BIT 7
`define LBCS_RIC_CODE 4'h5

// check type encodings
`define LBCS_CT_LRC8 2'h0
`define LBCS_CT_CRC16 2'h1
`define LBCS_CT_CCITT 2'h2

// interrupt status bits
`define LBCS_IRQ_RX_DONE 0
`define LBCS_IRQ_TX_DONE 1

`define LBCS_LINES 4
`define LBCS_LINE_W 2

`endif

// ### inc/lbcs_pkg.sv
package lbcs_pkg;

    typedef struct packed {
        logic send_first;
        logic send_second;
        logic esc_sending;
        logic expect_first;
        logic expect_second;
        logic send_req;
        logic expect_req;
        logic [15:0] accum;
    } lbcs_line_t;

    // transmit side events of one line
    typedef struct packed {
        logic count_zero;
        logic ctrl_fetch;
        logic [7:0] ctrl_byte;
        logic load_first;
        logic load_second;
        logic esc_load;
        logic esc_sent;
    } lbcs_tx_ev_t;

    // receive side events of one line
    typedef struct packed {
        logic count_zero;
        logic ctrl_fetch;
        logic [7:0] ctrl_byte;
        logic char_valid;
        logic [7:0] char_data;
    } lbcs_rx_ev_t;

    typedef enum logic [1:0] {
        LBCS_IDLE = 2'b00,
        LBCS_POST = 2'b01
    } lbcs_post_state_t;

endpackage

// ### src/lbcs_line.sv
`timescale 1ns/1ns
`include "lbcs_params.svh"

module lbcs_line
    import lbcs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration
    input wire logic [1:0] check_type,
    input wire logic wr_req,
    input wire logic send_req_wr,
    input wire logic expect_req_wr,
    // events
    input wire lbcs_tx_ev_t tx_ev,
    input wire lbcs_rx_ev_t rx_ev,
    // state out
    output lbcs_line_t line_q_o,
    output logic rx_done,
    output logic tx_done
);
    lbcs_line_t s_q, s_d;
    logic two_byte;
    logic take_char;

    assign two_byte = (check_type == `LBCS_CT_CRC16) || (check_type == `LBCS_CT_CCITT);
    assign take_char = rx_ev.char_valid && (s_q.expect_first || s_q.expect_second);

    always_comb begin
        s_d = s_q;
        rx_done = 1'b0;
        tx_done = 1'b0;
        if (wr_req) begin
            s_d.send_req = send_req_wr;
            s_d.expect_req = expect_req_wr;
        end
        // transmit progress
        if (tx_ev.load_first) begin
            s_d.send_first = 1'b0;
            s_d.send_second = two_byte;
            tx_done = !two_byte;
        end
        if (tx_ev.load_second) begin
            s_d.send_second = 1'b0;
            tx_done = 1'b1;
        end
        if ((tx_ev.count_zero && s_q.send_req)
            || (tx_ev.ctrl_fetch && tx_ev.ctrl_byte[`LBCS_CB_CHECK])) begin
            s_d.send_first = 1'b1;
        end
        if (tx_ev.esc_sent) begin
            s_d.esc_sending = 1'b0;
        end
        if (tx_ev.esc_load && tx_ev.ctrl_byte[`LBCS_CB_ESCAPE]) begin
            s_d.esc_sending = 1'b1;
        end
        // receive progress
        if (take_char) begin
            s_d.accum = s_q.accum ^ {s_q.accum[7:0], rx_ev.char_data};
            if (s_q.expect_first) begin
                s_d.expect_first = 1'b0;
                s_d.expect_second = two_byte;
                rx_done = !two_byte;
            end else begin
                s_d.expect_second = 1'b0;
                rx_done = 1'b1;
            end
        end
        if ((rx_ev.count_zero && s_q.expect_req)
            || (rx_ev.ctrl_fetch && rx_ev.ctrl_byte[`LBCS_CB_CHECK])) begin
            s_d.expect_first = 1'b1;
            if (!s_q.expect_first && !s_q.expect_second) begin
                s_d.accum = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign line_q_o = s_q;

    chk_second_follows: assert property (@(posedge clk) disable iff (rst)
        (take_char && s_q.expect_first && two_byte) |=> s_q.expect_second)
        else $error("second check flag not set after first check char");
    chk_lrc_no_second: assert property (@(posedge clk) disable iff (rst)
        (tx_ev.load_first && !two_byte && !tx_ev.load_second) |=> !s_q.send_second)
        else $error("send second flag left set under single byte check");
    chk_send_first_set: assert property (@(posedge clk) disable iff (rst)
        (tx_ev.count_zero && s_q.send_req) |=> s_q.send_first)
        else $error("send first flag not set at count zero");
    chk_second_clear: assert property (@(posedge clk) disable iff (rst)
        (tx_ev.load_second && !tx_ev.load_first) |=> !s_q.send_second)
        else $error("send second flag not cleared");
endmodule

// ### verification/lbcs_serial_model.sv
`timescale 1ns/1ns
`include "lbcs_params.svh"

module lbcs_serial_model
    import lbcs_pkg::*;
(
    // clock
    input wire logic clk,
    // per line events toward the block
    output lbcs_tx_ev_t [`LBCS_LINES-1:0] tx_ev,
    output lbcs_rx_ev_t [`LBCS_LINES-1:0] rx_ev
);
    initial begin
        tx_ev = '0;
        rx_ev = '0;
    end

    // ev = {count_zero, ctrl_fetch, load_first, load_second, esc_load, esc_sent}
    task automatic tx(input int ln, input logic [5:0] ev, input logic [7:0] b);
        @(posedge clk);
        tx_ev[ln] <= '{ev[5], ev[4], b, ev[3], ev[2], ev[1], ev[0]};
        @(posedge clk);
        // byte no longer qualified, so it must not keep its last value
        tx_ev[ln] <= '{1'b0, 1'b0, ~b, 1'b0, 1'b0, 1'b0, 1'b0};
    endtask

    // ev = {count_zero, ctrl_fetch, char_valid}
    task automatic rx(input int ln, input logic [2:0] ev, input logic [7:0] b);
        @(posedge clk);
        rx_ev[ln] <= '{ev[2], ev[1], b, ev[0], b};
        @(posedge clk);
        rx_ev[ln] <= '{1'b0, 1'b0, ~b, 1'b0, ~b};
    endtask
endmodule

// ### verification/testbench.sv
`timescale 1ns/1ns
`include "lbcs_params.svh"

module testbench
    import lbcs_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pend = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic [7:0] disc;
    logic disc_v;
    logic irq;
    logic [15:0] d;
    logic [31:0] q;
    logic [15:0] e;
    lbcs_tx_ev_t [`LBCS_LINES-1:0] tx_ev;
    lbcs_rx_ev_t [`LBCS_LINES-1:0] rx_ev;
    logic [31:0] rd_q[$];
    logic [7:0] disc_q[$];
    int error_cnt = 0;
    int checked = 0;

    always #4 clk = ~clk;

    lbcs_top u_lbcs_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_ev(tx_ev),
        .rx_ev(rx_ev), .discard_ctrl(disc), .discard_valid(disc_v), .irq(irq));

    lbcs_serial_model u_lbcs_serial_model (.clk(clk), .tx_ev(tx_ev), .rx_ev(rx_ev));

    // ----------------------------------------
    // compare and report
    // ----------------------------------------
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
        checked++;
        if ((got & m) !== (exp & m)) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got & m, exp & m);
        end
    endtask

    task report_and_stop;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (pend) begin
            q = rd_q.pop_front();
            cmp(reg_rdata, q[31:16], q[15:0]);
        end
        if (disc_v) begin
            e = (disc_q.size() > 0) ? {8'h00, disc_q.pop_front()} : 16'hFFFF;
            cmp({8'h00, disc}, e, 16'hFFFF);
        end
        pend <= reg_rd;
    end

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] x, input logic [15:0] m);
        @(posedge clk);
        rd_q.push_back({x, m});
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    task automatic prog(input logic [15:0] x);
        rd(`LBCS_ADDR_PROGRESS, x, 16'hFFFF);
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        void'($urandom(32'h3C8F));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        prog(16'h0000);
        rd(8'h20, 16'h0000, 16'hFFFF);
        cmp({15'h0000, irq}, 16'h0000, 16'h0001);
        wr(`LBCS_ADDR_CHECK_TYPE, 16'h0084);
        wr(`LBCS_ADDR_IRQ_MASK, 16'h0001);
        $display("test reset done");

        wr(`LBCS_ADDR_LINE_SEL, 16'h0000);
        wr(`LBCS_ADDR_PROGRESS, 16'h0400);
        prog(16'h0400);
        u_lbcs_serial_model.tx(0, 6'h20, 8'h00);
        prog(16'h0401);
        u_lbcs_serial_model.tx(0, 6'h08, 8'h00);
        prog(16'h0400);
        $display("test send lrc done");

        wr(`LBCS_ADDR_LINE_SEL, 16'h0001);
        u_lbcs_serial_model.tx(1, 6'h10, 8'h08);
        prog(16'h0001);
        u_lbcs_serial_model.tx(1, 6'h08, 8'h00);
        prog(16'h0002);
        u_lbcs_serial_model.tx(1, 6'h04, 8'h00);
        prog(16'h0000);
        rd(`LBCS_ADDR_IRQ_STAT, 16'h0002, 16'h0002);
        u_lbcs_serial_model.tx(1, 6'h02, 8'h02);
        prog(16'h0004);
        u_lbcs_serial_model.tx(1, 6'h01, 8'h00);
        prog(16'h0000);
        $display("test send crc done");

        wr(`LBCS_ADDR_LINE_SEL, 16'h0002);
        wr(`LBCS_ADDR_PROGRESS, 16'h0800);
        u_lbcs_serial_model.rx(2, 3'b100, 8'h00);
        prog(16'h0820);
        disc_q.push_back(8'h10);
        d = 16'($urandom);
        u_lbcs_serial_model.rx(2, 3'b001, d[7:0]);
        prog(16'h0800);
        rd(`LBCS_ADDR_RIC, {8'h25, d[7:0]}, 16'h3FFF);
        rd(`LBCS_ADDR_CTRL_BYTE, 16'h0010, 16'h00FF);
        rd(`LBCS_ADDR_SYS_CTRL, 16'h0080, 16'h0080);
        rd(`LBCS_ADDR_IRQ_STAT, 16'h0001, 16'h0001);
        cmp({15'h0000, irq}, 16'h0001, 16'h0001);
        wr(`LBCS_ADDR_IRQ_STAT, 16'h0001);
        repeat (2) @(posedge clk);
        cmp({15'h0000, irq}, 16'h0000, 16'h0001);
        $display("test expect lrc done");

        wr(`LBCS_ADDR_LINE_SEL, 16'h0003);
        u_lbcs_serial_model.rx(3, 3'b010, 8'h08);
        prog(16'h0020);
        d = 16'($urandom);
        u_lbcs_serial_model.rx(3, 3'b001, d[7:0]);
        prog(16'h0040);
        disc_q.push_back(8'h10);
        u_lbcs_serial_model.rx(3, 3'b001, d[15:8]);
        prog(16'h0000);
        rd(`LBCS_ADDR_RIC, 16'h3500, 16'h3F00);
        $display("test expect crc done");

        repeat (3) @(posedge clk);
        cmp(16'(disc_q.size()), 16'h0000, 16'hFFFF);
        report_and_stop();
    end

    // watchdog, far beyond the hundred or so cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
endmodule
